// ---- rtl/sspx_pkg.sv ----
// sspx_pkg: shared types and constants of the synchronous sram / fifo port
// assumes: included by every sspx design file through a wildcard import
package sspx_pkg;

   // data widths of the two instances and the latency select width
   localparam int SSPX_WIDE_DW = 64;
   localparam int SSPX_NARROW_DW = 16;
   localparam int SSPX_LAT_W = 2;

   // per-space setting word
   typedef struct packed {
      logic [SSPX_LAT_W-1:0] read_latency_sel;
      logic [SSPX_LAT_W-1:0] write_latency_sel;
      logic select_extend;
      logic read_enable_mode;
      logic sync_clock_sel;
   } sspx_cfg_s;

   localparam sspx_cfg_s SSPX_CFG_RST = '0;

   // synchroniser depth and deselect length
   localparam int SSPX_SYNC_STAGES = 2;
   localparam int SSPX_DESELECT_CYC = 1;

   typedef enum logic [1:0] {C_COLLECT, C_WAIT, C_DRAIN} sspx_cst_e;
   typedef enum logic {L_IDLE, L_RUN} sspx_lst_e;

endpackage // sspx_pkg

// ---- rtl/sspx_sync.sv ----
// sspx_sync: two-flop level synchroniser into the clock of clk_i
// assumes: d_i is a level that stays put for at least two destination edges
`timescale 1ns/100ps
module sspx_sync
   import sspx_pkg::*;
#(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // level in and out
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   initial begin
      if (W < 1 || SSPX_SYNC_STAGES != 2) $error("sspx_sync: bad width");
   end

   // meta_q feeds sync_q only
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;
endmodule // sspx_sync

// ---- rtl/sspx_buf2.sv ----
// sspx_buf2: two-entry valid/ready buffer, head entry drives the output
// assumes: one clock; in_ready_o and out_valid_o come straight from flops
`timescale 1ns/100ps
module sspx_buf2
   import sspx_pkg::*;
#(
   parameter int W = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   logic v0_q, v0_d, v1_q, v1_d;
   logic [W-1:0] e0_q, e0_d, e1_q, e1_d;
   logic push, pop;

   initial begin
      if (W < 1) $error("sspx_buf2: bad width");
   end

   assign push = in_valid_i && !v1_q;
   assign pop = v0_q && out_ready_i;

   always_comb begin
      v0_d = v0_q;
      v1_d = v1_q;
      e0_d = e0_q;
      e1_d = e1_q;
      if (pop) begin
         if (v1_q) begin
            e0_d = e1_q;
            v1_d = push;
            if (push) e1_d = in_data_i;
         end else begin
            e0_d = in_data_i;
            v0_d = push;
         end
      end else if (push) begin
         if (v0_q) begin
            e1_d = in_data_i;
            v1_d = 1'b1;
         end else begin
            e0_d = in_data_i;
            v0_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         v0_q <= 1'b0;
         v1_q <= 1'b0;
         e0_q <= '0;
         e1_q <= '0;
      end else begin
         v0_q <= v0_d;
         v1_q <= v1_d;
         e0_q <= e0_d;
         e1_q <= e1_d;
      end
   end

   assign in_ready_o = !v1_q;
   assign out_valid_o = v0_q;
   assign out_data_o = e0_q;
endmodule // sspx_buf2

// ---- rtl/sspx_port.sv ----
// sspx_port: synchronous sram / fifo access port, request side on clk_i,
// pin side on the selected external output clock
// assumes: space settings held steady by software; pins sampled by the memory
// Function
// - read latency per space is 0, 1, 2 or 3 interface cycles.
// - write latency per space is 0, 1, 2 or 3 interface cycles.
// - with select extend clear, select drops after the last command.
// - with select extend set, select stays low while output enable is low.
// - read enable mode clear: strobe is an address strobe plus deselect cycle.
// - read enable mode set: strobe is a fifo read enable, no deselect.
// - each space runs from one of two external clocks, by its clock select.
// - shared pins act as strobe, output enable and write enable.
// - outputs change after the rising edge; read data captured on it.
// - wide instance 64 data bits, 8 byte enables; narrow 16 and 2.
`timescale 1ns/100ps
module sspx_port
   import sspx_pkg::*;
#(
   parameter int DW = SSPX_WIDE_DW,
   parameter int AW = 20,
   parameter int NSPACE = 4,
   parameter int BMAX = 4
) (
   // clocks and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ext_clock_out_one_i,
   input wire logic ext_clock_out_two_i,
   // per-space settings
   input wire sspx_cfg_s [NSPACE-1:0] space_cfg_i,
   // request beats
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic req_write_i,
   input wire logic [$clog2(NSPACE)-1:0] req_space_i,
   input wire logic [AW-1:0] req_addr_i,
   input wire logic [DW/8-1:0] req_be_i,
   input wire logic [DW-1:0] req_wdata_i,
   input wire logic req_last_i,
   // read words
   output logic rsp_valid_o,
   input wire logic rsp_ready_i,
   output logic [DW-1:0] rsp_rdata_o,
   output logic rsp_last_o,
   // status
   output logic busy_o,
   output logic wr_done_o,
   // memory pins
   output logic [NSPACE-1:0] space_select_n_o,
   output logic [DW/8-1:0] byte_enable_n_o,
   output logic [AW-1:0] ext_address_o,
   output logic [DW-1:0] ext_data_o,
   output logic ext_data_oe_o,
   input wire logic [DW-1:0] ext_data_i,
   output logic sync_addr_strobe_n_o,
   output logic sync_output_enable_n_o,
   output logic sync_write_enable_n_o
);
   localparam int BEW = DW / 8;
   localparam int SW = $clog2(NSPACE);
   localparam int IW = $clog2(BMAX);
   localparam int CW = $clog2(BMAX + 1);
   localparam int PHW = $clog2(BMAX + 8);

   initial begin
      if (!(DW == SSPX_WIDE_DW || DW == SSPX_NARROW_DW)) $error("sspx_port: bad DW");
      if (NSPACE < 2 || BMAX < 2 || AW < 1) $error("sspx_port: bad size");
   end

   // ---------------- request side, clk_i ----------------
   sspx_cst_e cst_q, cst_d;
   logic [CW-1:0] bcnt_q, bcnt_d, dcnt_q, dcnt_d;
   logic [BMAX-1:0][AW-1:0] addr_q, addr_d;
   logic [BMAX-1:0][BEW-1:0] be_q, be_d;
   logic [BMAX-1:0][DW-1:0] wd_q, wd_d;
   logic wr_q, wr_d, clksel_q, clksel_d, req_tgl_q, req_tgl_d;
   logic rdy_q, rdy_d, busy_q, busy_d, wdone_q, wdone_d, ack_seen_q, ack_seen_d;
   logic [SW-1:0] sp_q, sp_d;
   sspx_cfg_s cfg_q, cfg_d;
   logic ack_s, bin_valid, bin_ready, drain_last;
   logic [BMAX-1:0][DW-1:0] rd_q, rd_d;
   // link-side flops that the request side watches through its synchroniser
   logic ack_tgl_q, ack_tgl_d;

   assign drain_last = (dcnt_q == bcnt_q - CW'(1));
   assign bin_valid = (cst_q == C_DRAIN);

   always_comb begin
      cst_d = cst_q;
      bcnt_d = bcnt_q;
      dcnt_d = dcnt_q;
      addr_d = addr_q;
      be_d = be_q;
      wd_d = wd_q;
      wr_d = wr_q;
      sp_d = sp_q;
      cfg_d = cfg_q;
      clksel_d = clksel_q;
      req_tgl_d = req_tgl_q;
      rdy_d = rdy_q;
      busy_d = busy_q;
      wdone_d = 1'b0;
      ack_seen_d = ack_seen_q;
      case (cst_q)
         C_COLLECT: begin
            if (req_valid_i && rdy_q) begin
               addr_d[bcnt_q[IW-1:0]] = req_addr_i;
               be_d[bcnt_q[IW-1:0]] = req_be_i;
               wd_d[bcnt_q[IW-1:0]] = req_wdata_i;
               // the first beat fixes direction, space and clock of the burst
               if (bcnt_q == '0) begin
                  wr_d = req_write_i;
                  sp_d = req_space_i;
                  cfg_d = space_cfg_i[req_space_i];
                  clksel_d = space_cfg_i[req_space_i].sync_clock_sel;
               end
               bcnt_d = bcnt_q + CW'(1);
               if (req_last_i || bcnt_q == CW'(BMAX - 1)) begin
                  cst_d = C_WAIT;
                  req_tgl_d = !req_tgl_q;
                  rdy_d = 1'b0;
                  busy_d = 1'b1;
               end
            end
         end
         C_WAIT: begin
            if (ack_s != ack_seen_q) begin
               ack_seen_d = ack_s;
               dcnt_d = '0;
               if (wr_q) begin
                  cst_d = C_COLLECT;
                  bcnt_d = '0;
                  rdy_d = 1'b1;
                  busy_d = 1'b0;
                  wdone_d = 1'b1;
               end else begin
                  cst_d = C_DRAIN;
               end
            end
         end
         C_DRAIN: begin
            // a stalled reader holds the drain here, so no word is lost
            if (bin_ready) begin
               dcnt_d = dcnt_q + CW'(1);
               if (drain_last) begin
                  cst_d = C_COLLECT;
                  bcnt_d = '0;
                  rdy_d = 1'b1;
                  busy_d = 1'b0;
               end
            end
         end
         default: cst_d = C_COLLECT;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cst_q <= C_COLLECT;
         bcnt_q <= '0;
         dcnt_q <= '0;
         addr_q <= '0;
         be_q <= '0;
         wd_q <= '0;
         wr_q <= 1'b0;
         sp_q <= '0;
         cfg_q <= SSPX_CFG_RST;
         clksel_q <= 1'b0;
         req_tgl_q <= 1'b0;
         rdy_q <= 1'b1;
         busy_q <= 1'b0;
         wdone_q <= 1'b0;
         ack_seen_q <= 1'b0;
      end else begin
         cst_q <= cst_d;
         bcnt_q <= bcnt_d;
         dcnt_q <= dcnt_d;
         addr_q <= addr_d;
         be_q <= be_d;
         wd_q <= wd_d;
         wr_q <= wr_d;
         sp_q <= sp_d;
         cfg_q <= cfg_d;
         clksel_q <= clksel_d;
         req_tgl_q <= req_tgl_d;
         rdy_q <= rdy_d;
         busy_q <= busy_d;
         wdone_q <= wdone_d;
         ack_seen_q <= ack_seen_d;
      end
   end

   // read words leave through the buffer; rd_q is steady once ack is seen
   sspx_buf2 #(.W(DW + 1)) u_rbuf (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .in_valid_i(bin_valid),
      .in_ready_o(bin_ready),
      .in_data_i({drain_last, rd_q[dcnt_q[IW-1:0]]}),
      .out_valid_o(rsp_valid_o),
      .out_ready_i(rsp_ready_i),
      .out_data_o({rsp_last_o, rsp_rdata_o})
   );

   sspx_sync #(.W(1)) u_ack_sync (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .d_i(ack_tgl_q),
      .q_o(ack_s)
   );

   assign req_ready_o = rdy_q;
   assign busy_o = busy_q;
   assign wr_done_o = wdone_q;

   // clock switches only while the pin side is idle; no burst sees a change
   chk_clk_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (cst_q != C_COLLECT && $past(cst_q) != C_COLLECT) |-> $stable(clksel_q))
      else $error("clock select moved during a burst");

   // ---------------- pin side, selected external clock ----------------
   logic link_clk, lrst_n, req_s;
   assign link_clk = clksel_q ? ext_clock_out_two_i : ext_clock_out_one_i;

   sspx_sync #(.W(1)) u_lrst_sync (
      .clk_i(link_clk),
      .nrst_i(nrst_i),
      .d_i(1'b1),
      .q_o(lrst_n)
   );

   sspx_sync #(.W(1)) u_req_sync (
      .clk_i(link_clk),
      .nrst_i(lrst_n),
      .d_i(req_tgl_q),
      .q_o(req_s)
   );

   sspx_lst_e lst_q, lst_d;
   logic [PHW-1:0] ph_q, ph_d, pk_q, n_ph, rl, wl, lat, des, last_ph, wk, rk;
   logic req_seen_q, req_seen_d, prun_q, prun_d;
   logic [NSPACE-1:0] sel_n_q, sel_n_d;
   logic [BEW-1:0] ben_q, ben_d;
   logic [AW-1:0] adr_q, adr_d;
   logic [DW-1:0] dat_q, dat_d;
   logic doe_q, doe_d, strb_n_q, strb_n_d, soe_n_q, soe_n_d, swe_n_q, swe_n_d;
   logic samp_q, samp_d;
   logic [IW-1:0] sidx_q, sidx_d;
   logic cmd, sync_output_enable, ce_low, strb, doe, samp;

   assign n_ph = PHW'(bcnt_q);
   assign rl = PHW'(cfg_q.read_latency_sel);
   assign wl = PHW'(cfg_q.write_latency_sel);
   assign lat = wr_q ? wl : rl;
   assign des = cfg_q.read_enable_mode ? '0 : PHW'(SSPX_DESELECT_CYC);
   assign last_ph = n_ph + lat + des - PHW'(1);
   assign wk = ph_q - wl;
   assign rk = ph_q - rl;
   assign cmd = (ph_q < n_ph);
   assign sync_output_enable = !wr_q && (ph_q < n_ph + rl);
   assign ce_low = cmd || (cfg_q.select_extend && sync_output_enable);
   assign strb = cfg_q.read_enable_mode ? (!wr_q && cmd) : (cmd || ph_q == n_ph);
   assign doe = wr_q && (ph_q >= wl) && (ph_q < wl + n_ph);
   assign samp = !wr_q && (ph_q >= rl) && (ph_q < rl + n_ph);

   always_comb begin
      lst_d = lst_q;
      ph_d = ph_q;
      req_seen_d = req_seen_q;
      ack_tgl_d = ack_tgl_q;
      rd_d = rd_q;
      prun_d = 1'b0;
      sel_n_d = '1;
      strb_n_d = 1'b1;
      soe_n_d = 1'b1;
      swe_n_d = 1'b1;
      doe_d = 1'b0;
      samp_d = 1'b0;
      adr_d = adr_q;
      ben_d = ben_q;
      dat_d = dat_q;
      sidx_d = sidx_q;
      // memory word is taken at the rising edge that closes its cycle
      if (samp_q) rd_d[sidx_q] = ext_data_i;
      case (lst_q)
         L_IDLE: begin
            if (req_s != req_seen_q) begin
               req_seen_d = req_s;
               lst_d = L_RUN;
               ph_d = '0;
            end
         end
         L_RUN: begin
            if (ph_q == last_ph + PHW'(1)) begin
               lst_d = L_IDLE;
               ack_tgl_d = !ack_tgl_q;
            end else begin
               ph_d = ph_q + PHW'(1);
               prun_d = 1'b1;
               sel_n_d = ~(NSPACE'(ce_low) << sp_q);
               strb_n_d = !strb;
               soe_n_d = !sync_output_enable;
               swe_n_d = !(wr_q && cmd);
               if (cmd) begin
                  adr_d = addr_q[ph_q[IW-1:0]];
                  ben_d = ~be_q[ph_q[IW-1:0]];
               end
               doe_d = doe;
               if (doe) dat_d = wd_q[wk[IW-1:0]];
               samp_d = samp;
               sidx_d = rk[IW-1:0];
            end
         end
         default: lst_d = L_IDLE;
      endcase
   end

   // every pin is a flop on the link clock, so it moves just after the edge
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         lst_q <= L_IDLE;
         ph_q <= '0;
         pk_q <= '0;
         req_seen_q <= 1'b0;
         ack_tgl_q <= 1'b0;
         rd_q <= '0;
         prun_q <= 1'b0;
         sel_n_q <= '1;
         strb_n_q <= 1'b1;
         soe_n_q <= 1'b1;
         swe_n_q <= 1'b1;
         doe_q <= 1'b0;
         samp_q <= 1'b0;
         adr_q <= '0;
         ben_q <= '1;
         dat_q <= '0;
         sidx_q <= '0;
      end else begin
         lst_q <= lst_d;
         ph_q <= ph_d;
         pk_q <= ph_q;
         req_seen_q <= req_seen_d;
         ack_tgl_q <= ack_tgl_d;
         rd_q <= rd_d;
         prun_q <= prun_d;
         sel_n_q <= sel_n_d;
         strb_n_q <= strb_n_d;
         soe_n_q <= soe_n_d;
         swe_n_q <= swe_n_d;
         doe_q <= doe_d;
         samp_q <= samp_d;
         adr_q <= adr_d;
         ben_q <= ben_d;
         dat_q <= dat_d;
         sidx_q <= sidx_d;
      end
   end

   assign space_select_n_o = sel_n_q;
   assign byte_enable_n_o = ben_q;
   assign ext_address_o = adr_q;
   assign ext_data_o = dat_q;
   assign ext_data_oe_o = doe_q;
   assign sync_addr_strobe_n_o = strb_n_q;
   assign sync_output_enable_n_o = soe_n_q;
   assign sync_write_enable_n_o = swe_n_q;

   chk_rd_first: assert property (@(posedge link_clk) disable iff (!lrst_n)
      (samp_q && sidx_q == '0) |-> (pk_q == PHW'(cfg_q.read_latency_sel)))
      else $error("first read word sampled at the wrong cycle");

   chk_wr_first: assert property (@(posedge link_clk) disable iff (!lrst_n)
      $rose(doe_q) |-> (pk_q == PHW'(cfg_q.write_latency_sel) && $past(prun_d) == 1'b1))
      else $error("first write word driven at the wrong cycle");

   chk_sel_release: assert property (@(posedge link_clk) disable iff (!lrst_n)
      (prun_q && !cfg_q.select_extend && pk_q >= PHW'(bcnt_q)) |-> (&sel_n_q))
      else $error("select held after the last command");

   chk_sel_extend: assert property (@(posedge link_clk) disable iff (!lrst_n)
      (prun_q && cfg_q.select_extend && !soe_n_q) |-> !sel_n_q[sp_q])
      else $error("select dropped while output enable active");

   chk_deselect: assert property (@(posedge link_clk) disable iff (!lrst_n)
      (prun_q && !cfg_q.read_enable_mode && pk_q == PHW'(bcnt_q)) |-> (!strb_n_q && swe_n_q))
      else $error("missing deselect cycle");

   chk_no_deselect: assert property (@(posedge link_clk) disable iff (!lrst_n)
      (prun_q && cfg_q.read_enable_mode && !strb_n_q) |-> (!wr_q && pk_q < PHW'(bcnt_q)))
      else $error("read enable outside read commands");

   chk_pin_excl: assert property (@(posedge link_clk) disable iff (!lrst_n)
      !swe_n_q |-> (soe_n_q && !sel_n_q[sp_q]))
      else $error("write enable without select or with output enable");

   chk_rd_burst: assert property (@(posedge link_clk) disable iff (!lrst_n)
      (samp_q && $past(samp_q)) |-> (sidx_q == $past(sidx_q) + IW'(1)))
      else $error("burst read words not on successive cycles");
endmodule // sspx_port

// ---- dv/sspx_mem_model.sv ----
// sspx_mem_model: behavioural synchronous burst sram on the port's pins
// assumes: bench hands in the live latencies and the selected link clock
`timescale 1ns/100ps
module sspx_mem_model
   import sspx_pkg::*;
#(
   parameter int DW = 64,
   parameter int AW = 20
) (
   // link clock and latencies
   input wire logic lclk_i,
   input wire logic [1:0] rl_i,
   input wire logic [1:0] wl_i,
   // pins from the port
   input wire logic sel_any_n_i,
   input wire logic [DW/8-1:0] be_n_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] wdata_i,
   input wire logic strobe_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   // read data back
   output logic [DW-1:0] rdata_o
);
   logic [DW-1:0] mem [16];
   logic [3:0] ra_q [1:3];
   logic [3:0] wa_q [1:3];
   logic [DW/8-1:0] wb_q [1:3];
   logic [3:1] rv_q = '0;
   logic [3:1] wv_q = '0;
   logic [DW-1:0] last_q = '0;
   logic rcmd, wcmd, rok, wok;
   logic [3:0] rsel, wsel;
   logic [DW/8-1:0] wbe;
   assign rcmd = !sel_any_n_i && !strobe_n_i && !oe_n_i && we_n_i;
   assign wcmd = !sel_any_n_i && !we_n_i;
   always_comb begin
      rok = (rl_i == 2'h0) ? rcmd : rv_q[rl_i];
      rsel = (rl_i == 2'h0) ? addr_i[3:0] : ra_q[rl_i];
      wok = (wl_i == 2'h0) ? wcmd : wv_q[wl_i];
      wsel = (wl_i == 2'h0) ? addr_i[3:0] : wa_q[wl_i];
      wbe = (wl_i == 2'h0) ? be_n_i : wb_q[wl_i];
      // released bus shows the inverse of the last word, so stale data cannot pass
      rdata_o = rok ? mem[rsel] : ~last_q;
   end
   always @(posedge lclk_i) begin
      rv_q <= {rv_q[2:1], rcmd};
      wv_q <= {wv_q[2:1], wcmd};
      ra_q[1] <= addr_i[3:0];
      wa_q[1] <= addr_i[3:0];
      wb_q[1] <= be_n_i;
      for (int j = 3; j > 1; j--) begin
         ra_q[j] <= ra_q[j-1];
         wa_q[j] <= wa_q[j-1];
         wb_q[j] <= wb_q[j-1];
      end
      if (rok) last_q <= rdata_o;
      if (wok) for (int b = 0; b < DW/8; b++) if (!wbe[b]) mem[wsel][8*b +: 8] <= wdata_i[8*b +: 8];
   end
endmodule // sspx_mem_model

// ---- dv/testbench.sv ----
// testbench: request bursts into the wide port, checks read data and pin counts
// assumes: memory model on the pins, both link clocks free running
`timescale 1ns/100ps
module testbench;
   import sspx_pkg::*;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic ext_one = 1'b0;
   logic ext_two = 1'b1;
   sspx_cfg_s [3:0] cfg;
   logic [1:0] cur = 2'h0;
   logic req_valid_i = 1'b0, req_write_i = 1'b0, req_last_i = 1'b0, rsp_ready_i = 1'b0;
   logic [1:0] req_space_i = 2'h0;
   logic [19:0] req_addr_i = 20'h0, addr_o;
   logic [7:0] req_be_i = 8'h0, be_n;
   logic [63:0] req_wdata_i = 64'h0, rsp_rdata_o, wdata_o, rdata, bus;
   logic req_ready_o, rsp_valid_o, rsp_last_o, busy_o, wr_done_o, oe_d, stb_n, oe_n, we_n;
   logic [3:0] sel_n, seen_sel;
   logic lclk;
   int err_total = 0, tests_run = 0, c_sel, c_stb, c_oe, c_we;
   always #5 clk_i = ~clk_i;
   always #6 ext_one = ~ext_one;
   always #6 ext_two = ~ext_two;
   assign lclk = cfg[cur].sync_clock_sel ? ext_two : ext_one;
   assign bus = oe_d ? wdata_o : rdata;
   sspx_port dut (.clk_i(clk_i), .nrst_i(nrst_i), .ext_clock_out_one_i(ext_one),
      .ext_clock_out_two_i(ext_two), .space_cfg_i(cfg), .req_valid_i(req_valid_i),
      .req_ready_o(req_ready_o), .req_write_i(req_write_i), .req_space_i(req_space_i),
      .req_addr_i(req_addr_i), .req_be_i(req_be_i), .req_wdata_i(req_wdata_i),
      .req_last_i(req_last_i), .rsp_valid_o(rsp_valid_o), .rsp_ready_i(rsp_ready_i),
      .rsp_rdata_o(rsp_rdata_o), .rsp_last_o(rsp_last_o), .busy_o(busy_o),
      .wr_done_o(wr_done_o), .space_select_n_o(sel_n), .byte_enable_n_o(be_n),
      .ext_address_o(addr_o), .ext_data_o(wdata_o), .ext_data_oe_o(oe_d), .ext_data_i(bus),
      .sync_addr_strobe_n_o(stb_n), .sync_output_enable_n_o(oe_n),
      .sync_write_enable_n_o(we_n));
   sspx_mem_model sram (.lclk_i(lclk), .rl_i(cfg[cur].read_latency_sel),
      .wl_i(cfg[cur].write_latency_sel), .sel_any_n_i(&sel_n), .be_n_i(be_n),
      .addr_i(addr_o), .wdata_i(bus), .strobe_n_i(stb_n), .oe_n_i(oe_n), .we_n_i(we_n),
      .rdata_o(rdata));
   // idle pins add nothing, so clearing between bursts cannot race these counts
   always @(posedge lclk) begin
      seen_sel |= ~sel_n;
      c_sel += int'(sel_n != 4'hf);
      c_stb += int'(!stb_n);
      c_oe += int'(!oe_n);
      c_we += int'(!we_n);
   end
   function automatic logic [63:0] wd(input int i, input int k);
      return {8{i[3:0], k[3:0]}} ^ 64'h5a5a_0000_ffff_0000;
   endfunction
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask
   task automatic beat(input logic w, input int i, input int k, input logic [7:0] be,
                       input logic [63:0] d, input logic last);
      int n;
      req_valid_i = 1'b1;
      req_write_i = w;
      req_space_i = 2'(i);
      req_addr_i = 20'(i*4+k);
      req_be_i = be;
      req_wdata_i = d;
      req_last_i = last;
      n = 0;
      while (req_ready_o !== 1'b1 && n < 2000) begin
         @(negedge clk_i);
         n++;
      end
      @(negedge clk_i);
   endtask
   task automatic burst(input logic w, input int i, input int nb);
      c_sel = 0;
      c_stb = 0;
      c_oe = 0;
      c_we = 0;
      seen_sel = 4'h0;
      // four beats without last: the burst closes on the depth limit
      for (int k = 0; k < nb; k++) beat(w, i, k, 8'hff, wd(i, k), k == nb-1 && nb < 4);
      req_valid_i = 1'b0;
      chk({req_ready_o, busy_o}, 2'b01, "accept");
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (wr_done_o !== 1'b1 && n < 2000) begin
         @(negedge clk_i);
         n++;
      end
      chk(wr_done_o, 1'b1, "done");
      @(negedge clk_i);
      chk({wr_done_o, req_ready_o, busy_o}, 3'b010, "done pulse");
   endtask
   task automatic read_back(input int i, input logic [63:0] w0);
      int n, k;
      burst(1'b0, i, i+1);
      repeat (40) @(negedge clk_i);
      rsp_ready_i = 1'b1;
      k = 0;
      n = 0;
      while (k < i+1 && n < 2000) begin
         if (rsp_valid_o === 1'b1) begin
            chk(rsp_rdata_o, (k == 0) ? w0 : wd(i, k), "rdata");
            chk(rsp_last_o, k == i, "last");
            k++;
         end
         @(negedge clk_i);
         n++;
      end
      rsp_ready_i = 1'b0;
      chk(64'(k), 64'(i+1), "words");
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      logic [63:0] w0;
      for (int i = 0; i < 4; i++) begin
         cfg[i] = '{read_latency_sel: 2'(i), write_latency_sel: 2'(3-i),
            select_extend: 1'(i == 3), read_enable_mode: 1'(i % 2), sync_clock_sel: 1'(i / 2)};
      end
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      nrst_i = 1'b1;
      chk({req_ready_o, rsp_valid_o, busy_o, wr_done_o, oe_d}, 5'h10, "reset flags");
      chk({sel_n, stb_n, oe_n, we_n, be_n, addr_o}, {15'h7fff, 20'h0}, "reset pins");
      repeat (8) @(negedge clk_i);
      for (int i = 0; i < 4; i++) begin
         cur = 2'(i);
         burst(1'b1, i, i+1);
         wait_done();
         chk(64'(c_we), 64'(i+1), "we count");
         chk(64'(c_stb), 64'((i % 2) ? 0 : i+2), "wr strobes");
         chk(seen_sel, 4'h1 << i, "space");
         if (i != 3) chk(64'(c_sel), 64'(i+1), "wr select");
         w0 = wd(i, 0);
         beat(1'b1, i, 0, 8'h0f, ~w0, 1'b1);
         req_valid_i = 1'b0;
         wait_done();
         read_back(i, {w0[63:32], ~w0[31:0]});
         chk(64'(c_oe), 64'(2*i+1), "oe count");
         chk(64'(c_stb), 64'(i+1+((i % 2) ? 0 : 1)), "rd strobes");
         chk(64'(c_sel), 64'((i == 3) ? 2*i+1 : i+1), "rd select");
         $display("test %0d done", i);
      end
      finish_test();
   end
   initial begin
      #100000;
      err_total++;
      finish_test();
   end
endmodule // testbench
